// File: bench/arc_monitor.sv
`timescale 1ns/1ps
module arc_mon (
    input wire clock_in, rstn_in, sfr_wr_in, sfr_rd_in, sfr_sel_out,
    input wire [7:0] sfr_addr_in, sfr_page_in, sfr_wdata_in, sfr_rdata_out,
    input wire adc_bias_req_in, temp_bias_req_in, osc_bias_req_in,
    input wire ztc_bias_req_in, reference_source_select_out,
    input wire reference_buffer_enable_out, reference_level_select_out,
    input wire temp_sensor_enable_out, bias_generator_on_out,
    input wire zero_tc_bias_on_out
);
    wire w = sfr_wr_in & sfr_sel_out;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    src_sel_a: assert property (w |=>
        reference_source_select_out == $past(sfr_wdata_in[3]))
        else $error("src");
    bias_auto_a: assert property (adc_bias_req_in | osc_bias_req_in
        | temp_bias_req_in |-> bias_generator_on_out) else $error("bias auto");
    bias_temp_a: assert property (temp_sensor_enable_out
        |-> bias_generator_on_out) else $error("bias temp");
    ztc_demand_a: assert property (ztc_bias_req_in
        |-> zero_tc_bias_on_out) else $error("ztc demand");
    bias_force_a: assert property (w && sfr_wdata_in[1]
        |=> bias_generator_on_out) else $error("bias force");
    buf_en_a: assert property (w |=>
        reference_buffer_enable_out == $past(sfr_wdata_in[0]))
        else $error("buf");
    level_sel_a: assert property (w |=>
        reference_level_select_out == $past(sfr_wdata_in[4]))
        else $error("lvl");
    temp_en_a: assert property (w |=>
        temp_sensor_enable_out == $past(sfr_wdata_in[2]))
        else $error("temp");
    ztc_force_a: assert property (w && sfr_wdata_in[5]
        |=> zero_tc_bias_on_out) else $error("ztc");
    unused_bits_a: assert property (
        sfr_rdata_out[7:6] == 2'b00) else $error("unused bits");
    addr_dec_a: assert property (sfr_sel_out ==
        (sfr_addr_in == 8'hD1 && sfr_page_in == 8'h00)) else $error("decode");
endmodule // arc_mon
bind arc_analog_reference_control arc_mon mon_u (.*);

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] a = 8'hD1;
    reg [7:0] p = 8'h00;
    reg [7:0] d = 8'h00;
    reg [3:0] rq = 4'h0;
    wire [7:0] q;
    wire [5:0] o;
    integer mismatches = 0;
    integer comparisons = 0;
    integer i;
    reg [7:0] tv [0:3] = '{8'hFF, 8'h15, 8'h2A, 8'h00};

    arc_analog_reference_control dut_u (
        .clock_in(clk),
        .rstn_in(rstn),
        .sfr_addr_in(a),
        .sfr_page_in(p),
        .sfr_wr_in(wr),
        .sfr_rd_in(rd),
        .sfr_wdata_in(d),
        .sfr_rdata_out(q),
        .sfr_sel_out(),
        .adc_bias_req_in(rq[0]),
        .temp_bias_req_in(rq[1]),
        .osc_bias_req_in(rq[2]),
        .ztc_bias_req_in(rq[3]),
        .reference_buffer_enable_out(o[0]),
        .bias_generator_on_out(o[1]),
        .temp_sensor_enable_out(o[2]),
        .reference_source_select_out(o[3]),
        .reference_level_select_out(o[4]),
        .zero_tc_bias_on_out(o[5])
    );

    initial
    begin
        forever #20 clk = ~clk;
    end

    task chk;
        input string n;
        input [7:0] e;
        input [7:0] s;
        begin
            comparisons = comparisons + 1;
            if (s !== e)
            begin
                mismatches = mismatches + 1;
                $display("[ERR] %0s exp %h got %h", n, e, s);
            end
        end
    endtask

    task wrt;
        input [7:0] x;
        begin
            @(negedge clk);
            wr = 1'b1;
            d = x;
            @(negedge clk);
            wr = 1'b0;
        end
    endtask

    task rdc;
        input [7:0] e;
        begin
            @(negedge clk);
            rd = 1'b1;
            @(negedge clk);
            rd = 1'b0;
            chk("rdata", e, q);
        end
    endtask

    // Bias also follows temp sensor enable and the adc, temp and osc demands
    task outc;
        input [7:0] v;
        reg [7:0] e;
        begin
            e = 8'h00;
            e[0] = v[0];
            e[1] = v[1] | v[2] | (|rq[2:0]);
            e[2] = v[2];
            e[3] = v[3];
            e[4] = v[4];
            e[5] = v[5] | rq[3];
            chk("ctl", e, {2'b00, o});
        end
    endtask

    task t_reset;
        begin
            rdc(8'h00);
            outc(8'h00);
        end
    endtask

    task t_fields;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                wrt(tv[i]);
                outc(tv[i] & 8'h3F);
                rdc(tv[i] & 8'h3F);
            end
        end
    endtask

    // Miss on address, then on page: nothing may change
    task t_decode;
        begin
            wrt(8'h15);
            a = 8'hD2;
            wrt(8'h2A);
            rdc(8'h00);
            a = 8'hD1;
            p = 8'h01;
            wrt(8'h2A);
            p = 8'h00;
            rdc(8'h15);
        end
    endtask

    task t_bias;
        begin
            wrt(8'h00);
            for (i = 0; i < 5; i = i + 1)
            begin
                @(negedge clk);
                rq = 4'b0001 << i;
                #1;
                outc(8'h00);
            end
        end
    endtask

    // Reset in mid-run must clear a fully set register by one cycle later
    task t_midreset;
        begin
            wrt(8'h3F);
            outc(8'h3F);
            @(negedge clk);
            rstn = 1'b0;
            @(negedge clk);
            #1;
            outc(8'h00);
            @(negedge clk);
            rstn = 1'b1;
            rdc(8'h00);
            outc(8'h00);
            wrt(8'h00);
        end
    endtask

    task end_of_test;
        begin
            $display("mismatches %0d comparisons %0d", mismatches, comparisons);
            if (mismatches == 0 && comparisons > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // Tests take under 150 cycles; 2500 cycles means a hang
    initial
    begin
        #100000;
        mismatches = mismatches + 1;
        end_of_test;
    end

    initial
    begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        t_reset;
        t_fields;
        t_decode;
        t_bias;
        t_midreset;
        end_of_test;
    end
endmodule // testbench

// File: design/arc_analog_reference_control.v
`timescale 1ns/1ps
`include "arc_defs.vh"
module arc_analog_reference_control (
    input wire clock_in,
    input wire rstn_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_page_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_wdata_in,
    output reg [7:0] sfr_rdata_out,
    output wire sfr_sel_out,
    input wire adc_bias_req_in,
    input wire temp_bias_req_in,
    input wire osc_bias_req_in,
    input wire ztc_bias_req_in,
    output wire reference_source_select_out,
    output wire reference_buffer_enable_out,
    output wire reference_level_select_out,
    output wire temp_sensor_enable_out,
    output wire bias_generator_on_out,
    output wire zero_tc_bias_on_out
);
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // One decode serves both strobes, so they cannot disagree on a hit
    function arc_hit;
        input [7:0] addr;
        input [7:0] page;
        begin
            arc_hit = (addr == `ARC_REG_ADDR) &&
                (page == `ARC_REG_PAGE);
        end
    endfunction

    // Pulls one control bit out of the stored byte
    function arc_field;
        input [7:0] value;
        input integer pos;
        begin
            arc_field = value[pos];
        end
    endfunction

    // Read view of the stored byte with the unused bits forced low
    function [7:0] arc_read_view;
        input [7:0] value;
        begin
            arc_read_view = value & `ARC_USED_MASK;
        end
    endfunction

    // Any one demand is enough; none of them needs software help
    function arc_demand;
        input adc;
        input temp;
        input osc;
        input sensor_on;
        begin
            arc_demand = adc | temp |
                osc | sensor_on;
        end
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire hit;
    wire wr_hit;
    wire rd_hit;
    wire [7:0] ctrl_r;
    wire [7:0] mask_nxt;
    reg [7:0] wdata_nxt;
    reg [7:0] rdata_nxt;

    assign hit = arc_hit(sfr_addr_in, sfr_page_in);
    assign wr_hit = hit & sfr_wr_in;
    assign rd_hit = hit & sfr_rd_in;
    assign sfr_sel_out = hit;

    // ----------------------------------------
    // Write data
    // ----------------------------------------
    // Built field by field so no write can land on an unused bit
    always @*
    begin
        wdata_nxt = 8'h00;
        wdata_nxt[`ARC_BIT_BUF_EN] = sfr_wdata_in[`ARC_BIT_BUF_EN];
        wdata_nxt[`ARC_BIT_BIAS_FORCE] = sfr_wdata_in[`ARC_BIT_BIAS_FORCE];
        wdata_nxt[`ARC_BIT_TEMP_EN] = sfr_wdata_in[`ARC_BIT_TEMP_EN];
        wdata_nxt[`ARC_BIT_SRC_SEL] = sfr_wdata_in[`ARC_BIT_SRC_SEL];
        wdata_nxt[`ARC_BIT_LEVEL_SEL] = sfr_wdata_in[`ARC_BIT_LEVEL_SEL];
        wdata_nxt[`ARC_BIT_ZTC_FORCE] = sfr_wdata_in[`ARC_BIT_ZTC_FORCE];
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // The mask is a second guard on the unused bits at the storage itself
    assign mask_nxt = `ARC_USED_MASK;

    arc_reg8 #(
        .WIDTH(8)
    ) u_reg (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .wr_en_in(wr_hit),
        .wr_data_in(wdata_nxt),
        .wr_mask_in(mask_nxt),
        .q_out(ctrl_r)
    );

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // A write and a read on one edge return the old value
    always @*
    begin
        rdata_nxt = 8'h00;
        if (rd_hit)
        begin
            rdata_nxt = arc_read_view(ctrl_r);
        end
    end

    // Registered so read data stays stable for the core's sample edge
    always @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            sfr_rdata_out <= `ARC_RESET_VALUE;
        else
            sfr_rdata_out <= rdata_nxt;
    end

    // ----------------------------------------
    // Field taps
    // ----------------------------------------
    // Each control comes straight from a stored bit, so it never glitches
    wire src_sel;
    wire buf_en;
    wire level_sel;
    wire temp_en;
    wire bias_force;
    wire ztc_force;

    assign src_sel =
        arc_field(ctrl_r, `ARC_BIT_SRC_SEL);
    assign buf_en =
        arc_field(ctrl_r, `ARC_BIT_BUF_EN);
    assign level_sel =
        arc_field(ctrl_r, `ARC_BIT_LEVEL_SEL);
    assign temp_en =
        arc_field(ctrl_r, `ARC_BIT_TEMP_EN);
    assign bias_force =
        arc_field(ctrl_r, `ARC_BIT_BIAS_FORCE);
    assign ztc_force =
        arc_field(ctrl_r, `ARC_BIT_ZTC_FORCE);

    // ----------------------------------------
    // Reference source
    // ----------------------------------------
    // Low keeps the reference pin, for external and buffered use alike
    assign reference_source_select_out = src_sel;

    // ----------------------------------------
    // Reference buffer
    // ----------------------------------------
    // Left on, the buffer burns current; keeping it off is up to software
    assign reference_buffer_enable_out = buf_en;

    // ----------------------------------------
    // Reference level
    // ----------------------------------------
    assign reference_level_select_out = level_sel;

    // ----------------------------------------
    // Temperature sensor
    // ----------------------------------------
    assign temp_sensor_enable_out = temp_en;

    // ----------------------------------------
    // Analog bias generator
    // ----------------------------------------
    wire bias_demand;
    // Demand is combinational so bias never lags a peripheral enable
    assign bias_demand = arc_demand(
        adc_bias_req_in,
        temp_bias_req_in,
        osc_bias_req_in,
        temp_en);
    assign bias_generator_on_out =
        bias_force | bias_demand;

    // ----------------------------------------
    // Zero-TC bias
    // ----------------------------------------
    // The force bit must be set before the oscillator is suspended
    assign zero_tc_bias_on_out =
        ztc_force | ztc_bias_req_in;

endmodule // arc_analog_reference_control

// File: design/arc_defs.vh
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH
// ----------------------------------------
// Register placement
// ----------------------------------------
`define ARC_REG_ADDR 8'hD1
`define ARC_REG_PAGE 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ARC_BIT_BUF_EN 0
`define ARC_BIT_BIAS_FORCE 1
`define ARC_BIT_TEMP_EN 2
`define ARC_BIT_SRC_SEL 3
`define ARC_BIT_LEVEL_SEL 4
`define ARC_BIT_ZTC_FORCE 5
`define ARC_USED_MASK 8'h3F
`define ARC_RESET_VALUE 8'h00
`endif

// File: design/arc_reg8.v
`timescale 1ns/1ps
// ----------------------------------------
// Storage for the writable bits
// ----------------------------------------
module arc_reg8 #(
    parameter WIDTH = 8
) (
    input wire clock_in,
    input wire rstn_in,
    input wire wr_en_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire [WIDTH-1:0] wr_mask_in,
    output reg [WIDTH-1:0] q_out
);
    always @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            q_out <= {WIDTH{1'b0}};
        else if (wr_en_in)
            q_out <= wr_data_in & wr_mask_in;
    end
endmodule // arc_reg8
